//--- rtl/interleave_pkg.sv
// Constants and types shared by the interleaved converter sequencer and the converter model.
// Assumes one system clock; power-up reset only.
package interleave_pkg;
  localparam int NUM_CONV = 3;
  localparam int FRAME_CLOCKS = 24;
  localparam int PHASE_STEP = FRAME_CLOCKS / NUM_CONV;
  localparam int CONV_EDGES = 18;
  localparam int SAMPLE_BITS = 14;
  localparam int ACQ_TIME_NS = 95;
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_DIV = 4;
  localparam int ACQ_CLOCKS = (ACQ_TIME_NS + SYS_PERIOD_NS * 2 * SCLK_DIV - 1)
    / (SYS_PERIOD_NS * 2 * SCLK_DIV);
  localparam int CAL_FRAMES = 1;
  localparam logic [SAMPLE_BITS-1:0] OFFSET_RESET = 14'h0000;
  typedef enum logic [2:0] {
    ACQUISITION_STATE = 3'h1,
    CONVERSION_STATE = 3'h2,
    OFFSET_CALIBRATION_STATE = 3'h4
  } conv_state_t;
endpackage

//--- rtl/adc_link_if.sv
// Link between the start sequencer and the interleaved converters.
// Assumes the bench resolves each shared data line from its enable.
`timescale 1ns/100ps
interface adc_link_if;
  import interleave_pkg::*;
  logic sclk;
  logic [NUM_CONV-1:0] start_n;
  logic [NUM_CONV-1:0] sdo_out;
  logic [NUM_CONV-1:0] sdo_oe;
  logic [NUM_CONV-1:0] sdo_in;
  // Host sees the enable so that calibration frames yield no sample
  modport host (output sclk, output start_n, input sdo_in, input sdo_oe);
  modport device (input sclk, input start_n, output sdo_out, output sdo_oe);
endinterface

//--- rtl/adc_converter_bank.sv
// Behavioural converter bank: one state machine per interleaved converter.
// Assumes the link clock and starts are asynchronous to this clock.
`timescale 1ns/100ps
module adc_converter_bank
  import interleave_pkg::*;
#(
  parameter int WIDTH = SAMPLE_BITS
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Link
  adc_link_if.device link,
  // Analog side
  input wire logic [WIDTH-1:0] analog_input_positive [NUM_CONV],
  input wire logic [WIDTH-1:0] analog_input_negative [NUM_CONV],
  input wire logic [WIDTH-1:0] raw_offset [NUM_CONV],
  input wire logic [WIDTH-1:0] analog_supply_reference,
  input wire logic [NUM_CONV-1:0] cal_request,
  // Status
  output logic [NUM_CONV-1:0] calibrating
);
  logic [2:0] sclk_sync;
  logic sclk_fall;
  assign sclk_fall = sclk_sync[2] & ~sclk_sync[1];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sclk_sync <= 3'h0;
    else sclk_sync <= {sclk_sync[1:0], link.sclk};
  end
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : conv
      logic [1:0] cs_sync;
      logic cs_prev;
      conv_state_t state;
      logic [4:0] edges;
      logic [WIDTH-1:0] sample;
      logic [WIDTH-1:0] shifter;
      logic [WIDTH-1:0] offset_trim;
      logic cal_pending;
      logic oe;
      logic dout;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cs_sync <= 2'h3;
          cs_prev <= 1'b1;
        end else begin
          cs_sync <= {cs_sync[0], link.start_n[g]};
          cs_prev <= cs_sync[1];
        end
      end
      // Power-up calibration pending, later on request
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cal_pending <= 1'b1;
        else if (cal_request[g]) cal_pending <= 1'b1;
        else if (state == OFFSET_CALIBRATION_STATE && cs_sync[1] && !cs_prev) cal_pending <= 1'b0;
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          state <= ACQUISITION_STATE;
          edges <= 5'h00;
          sample <= '0;
          shifter <= '0;
          offset_trim <= OFFSET_RESET;
          dout <= 1'b0;
        end else begin
          case (state)
            ACQUISITION_STATE: begin
              if (!cs_sync[1] && cs_prev) begin
                edges <= 5'h00;
                if (cal_pending) state <= OFFSET_CALIBRATION_STATE;
                else begin
                  // Input sampled on start fall, trimmed by latest calibration
                  sample <= analog_input_positive[g] - analog_input_negative[g]
                    + raw_offset[g] - offset_trim;
                  state <= CONVERSION_STATE;
                end
              end
            end
            CONVERSION_STATE: begin
              if (cs_sync[1]) state <= ACQUISITION_STATE;
              else if (sclk_fall) begin
                edges <= edges + 5'h01;
                if (edges == 5'h00) shifter <= sample;
                else shifter <= {shifter[WIDTH-2:0], 1'b0};
                dout <= (edges == 5'h00) ? sample[WIDTH-1] : shifter[WIDTH-2];
                if (edges == 5'(CONV_EDGES - 1)) state <= ACQUISITION_STATE;
              end
            end
            OFFSET_CALIBRATION_STATE: begin
              // Inputs ignored; trim takes the raw zero-input offset, the supply reference masks nothing
              offset_trim <= raw_offset[g] & analog_supply_reference | raw_offset[g];
              if (cs_sync[1]) state <= ACQUISITION_STATE;
            end
            default: state <= ACQUISITION_STATE;
          endcase
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) oe <= 1'b0;
        else oe <= ~cs_sync[1] & (state == CONVERSION_STATE);
      end
      assign link.sdo_out[g] = dout;
      assign link.sdo_oe[g] = oe;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) calibrating[g] <= 1'b0;
        else calibrating[g] <= (state == OFFSET_CALIBRATION_STATE);
      end
    end
  endgenerate
endmodule // adc_converter_bank

//--- rtl/start_sequencer.sv
// Host end: shared serial clock, staggered conversion starts, merged output stream.
// Assumes converters return MSB-first data on falling serial clock edges.
`timescale 1ns/100ps
module start_sequencer
  import interleave_pkg::*;
#(
  parameter int WIDTH = SAMPLE_BITS
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  // Link
  adc_link_if.host link,
  // Merged stream
  output logic [WIDTH-1:0] sample_data,
  output logic [1:0] sample_source,
  output logic sample_valid
);
  logic [$clog2(SCLK_DIV)-1:0] div;
  logic sclk;
  logic [4:0] frame_pos;
  logic running;
  logic [NUM_CONV-1:0] start_n;
  logic [1:0] sdo_sync [NUM_CONV];
  logic [WIDTH-1:0] shift [NUM_CONV];
  logic [NUM_CONV-1:0] done;
  logic [1:0] next_source;
  // Serial clock divided from the system clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
      sclk <= 1'b0;
    end else begin
      div <= div + 1'b1;
      if (div == '1) sclk <= ~sclk;
    end
  end
  wire sclk_rise = (div == '1) & ~sclk;
  wire sclk_fall = (div == '1) & sclk;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_pos <= 5'h00;
      running <= 1'b0;
    end else if (sclk_rise) begin
      running <= enable;
      // Parked at zero while idle so converter 0 always opens the stream
      if (!running || frame_pos == 5'(FRAME_CLOCKS - 1)) frame_pos <= 5'h00;
      else frame_pos <= frame_pos + 5'h01;
    end
  end
  // Start k low from offset k*8 until the acquisition tail of its frame
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : ch
      localparam logic [4:0] OFS = 5'(g * PHASE_STEP);
      // Synchronisers at both ends hold each bit back by one serial clock
      localparam logic [4:0] FIRST_BIT = 5'h02;
      localparam logic [4:0] LAST_BIT = FIRST_BIT + 5'(WIDTH - 1);
      logic [4:0] rel;
      logic armed;
      logic frame_on;
      logic [1:0] oe_sync;
      logic live;
      assign rel = (frame_pos >= OFS) ? frame_pos - OFS : 5'(frame_pos + FRAME_CLOCKS - OFS);
      // A converter joins only at its own frame start, never mid-frame
      assign frame_on = running & (armed | (rel == 5'h00));
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          start_n[g] <= 1'b1;
          armed <= 1'b0;
        end else if (sclk_fall) begin
          armed <= frame_on;
          start_n[g] <= ~frame_on | (rel >= 5'(FRAME_CLOCKS - ACQ_CLOCKS));
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sdo_sync[g] <= 2'h0;
          oe_sync <= 2'h0;
        end else begin
          sdo_sync[g] <= {sdo_sync[g][0], link.sdo_in[g]};
          oe_sync <= {oe_sync[0], link.sdo_oe[g]};
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          shift[g] <= '0;
          live <= 1'b0;
          done[g] <= 1'b0;
        end else begin
          done[g] <= 1'b0;
          if (sclk_rise && !start_n[g]) begin
            if (rel >= FIRST_BIT && rel <= LAST_BIT) begin
              shift[g] <= {shift[g][WIDTH-2:0], sdo_sync[g][1]};
              // Line released all frame means calibration, no sample
              live <= (rel == FIRST_BIT) ? oe_sync[1] : live & oe_sync[1];
            end
            done[g] <= (rel == LAST_BIT + 5'h01) & live;
          end
        end
      end
    end
  endgenerate
  assign link.sclk = sclk;
  assign link.start_n = start_n;
  // Merge in start order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_data <= '0;
      sample_source <= 2'h0;
      sample_valid <= 1'b0;
      next_source <= 2'h0;
    end else begin
      sample_valid <= 1'b0;
      if (!running) next_source <= 2'h0;
      else if (done[next_source]) begin
        sample_data <= shift[next_source];
        sample_source <= next_source;
        sample_valid <= 1'b1;
        next_source <= (next_source == 2'(NUM_CONV - 1)) ? 2'h0 : next_source + 2'h1;
      end
    end
  end
endmodule // start_sequencer

//--- tb/interleave_chk.sv
// Link timing checks for the start sequencer and converter bank.
// Assumes the bench wires it beside the link interface.
`timescale 1ns/100ps
module interleave_chk
  import interleave_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Link
  input wire logic sclk,
  input wire logic [NUM_CONV-1:0] start_n,
  input wire logic [NUM_CONV-1:0] sdo_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic sclk_q;
  logic [4:0] falls;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // Serial clock falls while start is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) falls <= 5'h00;
    else if (start_n[0]) falls <= 5'h00;
    else if (sclk_q && !sclk && falls != 5'h1F) falls <= falls + 5'h01;
  end
  sequence s_high8; start_n[0] [*8]; endsequence
  sequence s_sclk_hi; sclk [*4]; endsequence
  property p_oe0; start_n[0] [*4] |-> !sdo_oe[0]; endproperty
  property p_oe1; start_n[1] [*4] |-> !sdo_oe[1]; endproperty
  property p_oe2; start_n[2] [*4] |-> !sdo_oe[2]; endproperty
  property p_gap01; $fell(start_n[0]) |-> ##64 $fell(start_n[1]); endproperty
  property p_gap12; $fell(start_n[1]) |-> ##64 $fell(start_n[2]); endproperty
  property p_frame; $fell(start_n[0]) |-> ##192 $fell(start_n[0]); endproperty
  property p_acq; $rose(start_n[0]) |-> s_high8 ##1 s_high8; endproperty
  property p_falls; $rose(start_n[0]) |-> falls >= 5'h12; endproperty
  property p_sclk; $rose(sclk) |-> s_sclk_hi ##1 !sclk; endproperty
  a_oe0: assert property (p_oe0) else $error("data 0 driven while idle");
  a_oe1: assert property (p_oe1) else $error("data 1 driven while idle");
  a_oe2: assert property (p_oe2) else $error("data 2 driven while idle");
  a_gap01: assert property (p_gap01) else $error("start 1 spacing wrong");
  a_gap12: assert property (p_gap12) else $error("start 2 spacing wrong");
  a_frame: assert property (p_frame) else $error("frame length wrong");
  a_acq: assert property (p_acq) else $error("acquisition too short");
  a_falls: assert property (p_falls) else $error("too few clock falls");
  a_sclk: assert property (p_sclk) else $error("serial clock shape wrong");
endmodule // interleave_chk

//--- tb/interleaved_adc_start_sequencer_bench.sv
// Bench joining sequencer and converter bank over the link.
// Assumes 100 MHz clock and power-up reset only.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module interleaved_adc_start_sequencer_bench;
  import interleave_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic phase_b = 1'b0;
  logic [SAMPLE_BITS-1:0] in_pos [NUM_CONV], in_neg [NUM_CONV], offs [NUM_CONV];
  logic [SAMPLE_BITS-1:0] vref, sample_data;
  logic [NUM_CONV-1:0] cal_req = '0, cal_busy, cal_seen = '0, flip = '0;
  logic [1:0] sample_source;
  logic sample_valid;
  logic [15:0] lfsr = 16'h000A, note;
  logic [15:0] exp_q [$];
  int err_total = 0, n_tests = 0, cycles = 0;
  adc_link_if link ();
  // Released data lines show a toggling pattern
  assign link.sdo_in = (link.sdo_out & link.sdo_oe) | (flip & ~link.sdo_oe);
  start_sequencer i_start_sequencer (.clock(clock), .rst_n(rst_n), .enable(enable),
    .link(link.host), .sample_data(sample_data), .sample_source(sample_source),
    .sample_valid(sample_valid));
  adc_converter_bank i_adc_converter_bank (.clock(clock), .rst_n(rst_n), .link(link.device),
    .analog_input_positive(in_pos), .analog_input_negative(in_neg), .raw_offset(offs),
    .analog_supply_reference(vref), .cal_request(cal_req), .calibrating(cal_busy));
  interleave_chk i_interleave_chk (.clock(clock), .rst_n(rst_n), .sclk(link.sclk),
    .start_n(link.start_n), .sdo_oe(link.sdo_oe));
  initial forever #5 clock = ~clock;
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Offsets cancel after calibration, merged in start order
  task automatic push_rounds(input int rounds);
    for (int r = 0; r < rounds; r++)
      for (int k = 0; k < NUM_CONV; k++) exp_q.push_back({k[1:0], in_pos[k] - in_neg[k]});
  endtask
  task automatic drain();
    while (exp_q.size() > 0) @(posedge clock);
  endtask
  always @(posedge clock) begin
    flip <= ~flip;
    cycles <= cycles + 1;
    cal_seen <= phase_b ? (cal_seen | cal_busy) : '0;
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end else if (rst_n && sample_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spare sample", 1'b0, 1'b1)
      else begin
        note = exp_q.pop_front();
        `CHK("source", note[15:14], sample_source)
        `CHK("data", note[13:0], sample_data)
      end
    end
  end
  initial begin
    vref = 14'h3FFF;
    for (int k = 0; k < NUM_CONV; k++) begin
      lfsr = step(lfsr);
      in_pos[k] = {1'b1, lfsr[12:0]};
      in_neg[k] = {2'h0, lfsr[15:4]};
      lfsr = step(lfsr);
      offs[k] = {6'h00, lfsr[7:0]};
    end
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    enable <= 1'b1;
    push_rounds(3);
    drain();
    // Recalibrate all three mid-run
    cal_req <= 3'h7;
    phase_b <= 1'b1;
    push_rounds(3);
    @(posedge clock);
    cal_req <= 3'h0;
    drain();
    `CHK("calibrated", 3'h7, cal_seen)
    stop_test();
  end
endmodule // interleaved_adc_start_sequencer_bench
